// ### src/tpg_pkg.sv
/*
 tpg_pkg: offsets, reset values, field positions and modes of the
 pattern generator / detector of one channel.
 assumes: 8-bit register port, bit-serial data paths.
*/
package tpg_pkg;
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_GEN = 8'h10;
   localparam logic [7:0] OFF_DET = 8'h11;
   localparam logic [7:0] OFF_USR_LO = 8'h12;
   localparam logic [7:0] OFF_USR_MID = 8'h13;
   localparam logic [7:0] OFF_USR_HI = 8'h14;
   localparam logic [7:0] OFF_STATUS = 8'h1f;
   localparam logic [7:0] RST_GEN = 8'h00;
   localparam logic [7:0] RST_DET = 8'h03;
   localparam logic [7:0] RST_USER = 8'h55;
   localparam logic [7:0] GEN_MASK = 8'h7f;
   localparam logic [7:0] DET_MASK = 8'h0f;
   localparam int GEN_CK_BIT = 6;
   localparam int GEN_EN_LSB = 4;
   localparam int GEN_DIR_BIT = 3;
   localparam int GEN_INV_BIT = 2;
   localparam int GEN_POLY_LSB = 0;
   localparam int DET_DIR_BIT = 3;
   localparam int DET_INV_BIT = 2;
   localparam int DET_SEL_LSB = 0;
   localparam logic [1:0] EN_OFF = 2'h0;
   localparam logic [1:0] EN_PRBS = 2'h1;
   localparam logic [1:0] EN_USER = 2'h2;
   localparam logic [1:0] EN_IB = 2'h3;
   localparam logic [1:0] DSEL_USER = 2'h3;
   localparam logic [2:0] CNT_SRC_PATTERN = 3'h7;
   localparam logic [4:0] USER_MSB = 5'h17;
   localparam logic [2:0] IB_MIN_MSB = 3'h4;
   localparam logic [4:0] LOCK_MATCHES = 5'h18;
   localparam int FIFO_W = 1;
   localparam int FIFO_DEPTH = 16;
   typedef enum logic {TPG_HUNT, TPG_LOCK} tpg_det_state_t;
   // sel 00: 2^20-1, 01: 2^15-1, 1x: 2^11-1; history newest bit in [0]
   function automatic logic prbs_fb(input logic [1:0] sel, input logic [23:0] h);
      logic r;
      r = 1'b0;
      case (sel)
         2'h0: r = h[19] ^ h[16];
         2'h1: r = h[14] ^ h[13];
         default: r = h[10] ^ h[8];
      endcase
      return r;
   endfunction
endpackage

// ### src/tpg_top.sv
/*
 tpg_top: pattern generator and detector of one line channel, with a
 16-word fifo in front of the detector, and tpg_fifo.
 assumes: all bit-rate clocks arrive as one-cycle enables on REF_CLK;
 the error-insert bit and inband code live in neighbouring logic.
*/
// What this block does
// - two-bit enable picks off, prbs, user, inband
// - direction bit picks transmit or receive insertion
// - receive generation clocked by crystal or recovered
// - transmit crystal, clock input, or recovered in rz
// - generator invert flips prbs and user bits
// - polynomial field picks 2^20, 2^15, 2^11
// - detector watches receive or transmit path
// - detector invert flips data before compare
// - detector field picks three prbs or user
// - 24-bit user pattern, bit 23 first
// - inband code repeats msb first until stopped
// - rising insert control corrupts one prbs or user bit
// - source 111 counts detector mismatches
`timescale 1ns/1ns
`default_nettype none
module tpg_fifo #(
   parameter int W = 1,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [W-1:0] mem [DEPTH];
   logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
   logic [AW:0] cnt_q, cnt_d;
   logic full_q, full_d, empty_q, empty_d;
   logic push, pop;
   always_comb begin
      push = in_valid && !full_q;
      pop = out_ready && !empty_q;
      wp_d = push ? wp_q + 1'b1 : wp_q;
      rp_d = pop ? rp_q + 1'b1 : rp_q;
      cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
      full_d = (cnt_d == (AW + 1)'(DEPTH));
      empty_d = (cnt_d == '0);
   end
   always_ff @(posedge clk) begin
      if (rst) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
         full_q <= 1'b0;
         empty_q <= 1'b1;
      end else begin
         wp_q <= wp_d;
         rp_q <= rp_d;
         cnt_q <= cnt_d;
         full_q <= full_d;
         empty_q <= empty_d;
      end
   end
   // storage needs no reset; empty guards stale words
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wp_q] <= in_data;
      end
   end
   assign in_ready = !full_q;
   assign out_valid = !empty_q;
   assign out_data = mem[rp_q];
endmodule

module tpg_top (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic [7:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic [7:0] REG_RDATA,
   // bit-rate enables
   input wire logic REFERENCE_CRYSTAL_CLOCK_EN,
   input wire logic RX_REC_CLK_EN,
   input wire logic TX_CLK_EN,
   input wire logic TX_RZ_REC_CLK_EN,
   input wire logic TX_DUAL_RZ,
   // transmit path
   input wire logic TX_DATA_IN,
   input wire logic TX_DATA_EN,
   output logic TX_DATA_OUT,
   // receive path
   input wire logic RX_DATA_IN,
   input wire logic RX_DATA_EN,
   output logic RX_DATA_OUT,
   // inband code and error controls
   input wire logic [7:0] INBAND_CODE,
   input wire logic [1:0] INBAND_LEN,
   input wire logic ERROR_INSERT,
   output logic ERROR_INSERT_DONE,
   input wire logic [2:0] ERR_CNT_SRC,
   output logic ERR_EVENT,
   input wire logic ERR_READY,
   output logic MON_READY
);
   logic [7:0] gen_q, gen_d, det_q, det_d;
   logic [23:0] usr_q, usr_d;
   logic [7:0] rdata_q, rdata_d;
   logic [23:0] lfsr_q, lfsr_d, hist_q, hist_d;
   logic [4:0] uidx_q, uidx_d, didx_q, didx_d, mcnt_q, mcnt_d;
   logic [2:0] ibidx_q, ibidx_d;
   logic ins_prev_q, ins_prev_d, ins_pend_q, ins_pend_d;
   logic done_q, done_d, tx_q, tx_d, rx_q, rx_d, err_q, err_d;
   logic mon_rdy_q, mon_rdy_d;
   tpg_pkg::tpg_det_state_t st_q, st_d;
   logic [1:0] gen_en, poly, dsel;
   logic gen_rx, tick, gbit, pbit, fb, mon_bit, mon_en, mon_full;
   logic f_valid, f_ready, f_data, b, exp_bit, mism;
   logic [2:0] ib_msb;
   logic [23:0] win;

   // monitored data buffered; detector stalls while an event waits
   tpg_fifo #(.W(tpg_pkg::FIFO_W), .DEPTH(tpg_pkg::FIFO_DEPTH)) u_fifo (
      .clk(REF_CLK),
      .rst(SYS_RST),
      .in_valid(mon_en),
      .in_ready(mon_full),
      .in_data(mon_bit),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data(f_data)
   );

   always_comb begin
      gen_d = gen_q;
      det_d = det_q;
      usr_d = usr_q;
      rdata_d = 8'h00;
      gen_en = gen_q[tpg_pkg::GEN_EN_LSB +: 2];
      poly = gen_q[tpg_pkg::GEN_POLY_LSB +: 2];
      dsel = det_q[tpg_pkg::DET_SEL_LSB +: 2];
      gen_rx = gen_q[tpg_pkg::GEN_DIR_BIT];
      // register writes; each copy only steers this channel
      if (REG_WR) begin
         case (REG_ADDR)
            tpg_pkg::OFF_GEN: gen_d = REG_WDATA & tpg_pkg::GEN_MASK;
            tpg_pkg::OFF_DET: det_d = REG_WDATA & tpg_pkg::DET_MASK;
            tpg_pkg::OFF_USR_LO: usr_d[7:0] = REG_WDATA;
            tpg_pkg::OFF_USR_MID: usr_d[15:8] = REG_WDATA;
            tpg_pkg::OFF_USR_HI: usr_d[23:16] = REG_WDATA;
            default: ;
         endcase
      end
      if (REG_RD) begin
         case (REG_ADDR)
            tpg_pkg::OFF_GEN: rdata_d = gen_q;
            tpg_pkg::OFF_DET: rdata_d = det_q;
            tpg_pkg::OFF_USR_LO: rdata_d = usr_q[7:0];
            tpg_pkg::OFF_USR_MID: rdata_d = usr_q[15:8];
            tpg_pkg::OFF_USR_HI: rdata_d = usr_q[23:16];
            tpg_pkg::OFF_STATUS: rdata_d = {4'h0, !mon_rdy_q, err_q, gen_en != tpg_pkg::EN_OFF,
                                            st_q == tpg_pkg::TPG_LOCK};
            default: rdata_d = 8'h00;
         endcase
      end
      // generator bit clock
      if (!gen_q[tpg_pkg::GEN_CK_BIT]) begin
         tick = REFERENCE_CRYSTAL_CLOCK_EN;
      end else if (gen_rx) begin
         tick = RX_REC_CLK_EN;
      end else begin
         tick = TX_DUAL_RZ ? TX_RZ_REC_CLK_EN : TX_CLK_EN;
      end
      lfsr_d = lfsr_q;
      uidx_d = uidx_q;
      ibidx_d = ibidx_q;
      ib_msb = tpg_pkg::IB_MIN_MSB + {1'b0, INBAND_LEN};
      fb = tpg_pkg::prbs_fb(poly, lfsr_q);
      pbit = fb;
      gbit = 1'b0;
      ins_prev_d = ERROR_INSERT;
      ins_pend_d = ins_pend_q || (ERROR_INSERT && !ins_prev_q);
      done_d = 1'b0;
      if (tick) begin
         case (gen_en)
            tpg_pkg::EN_PRBS: begin
               // all-zero state would lock the register up
               lfsr_d = (lfsr_q[19:0] == 20'h00000) ? 24'h000001 : {lfsr_q[22:0], fb};
               gbit = pbit;
            end
            tpg_pkg::EN_USER: begin
               gbit = usr_q[uidx_q];
               uidx_d = (uidx_q == 5'h00) ? tpg_pkg::USER_MSB : uidx_q - 5'h01;
            end
            tpg_pkg::EN_IB: begin
               gbit = INBAND_CODE[ibidx_q];
               ibidx_d = (ibidx_q == 3'h0 || ibidx_q > ib_msb) ? ib_msb : ibidx_q - 3'h1;
            end
            default: ;
         endcase
         if (gen_en == tpg_pkg::EN_PRBS || gen_en == tpg_pkg::EN_USER) begin
            gbit = gbit ^ gen_q[tpg_pkg::GEN_INV_BIT];
            if (ins_pend_q) begin
               gbit = !gbit;
               ins_pend_d = ERROR_INSERT && !ins_prev_q;
               done_d = 1'b1;
            end
         end
      end
      // user or inband mode left and re-entered starts again at its first bit
      uidx_d = (gen_en == tpg_pkg::EN_USER) ? uidx_d : tpg_pkg::USER_MSB;
      ibidx_d = (gen_en == tpg_pkg::EN_IB) ? ibidx_d : ib_msb;
      // insertion point; ungenerated path passes through
      tx_d = TX_DATA_EN ? TX_DATA_IN : tx_q;
      rx_d = RX_DATA_EN ? RX_DATA_IN : rx_q;
      if (gen_en != tpg_pkg::EN_OFF && tick) begin
         if (gen_rx) begin
            rx_d = gbit;
         end else begin
            tx_d = gbit;
         end
      end
      // detector input selection
      if (det_q[tpg_pkg::DET_DIR_BIT]) begin
         mon_bit = TX_DATA_IN;
         mon_en = TX_DATA_EN;
      end else begin
         mon_bit = RX_DATA_IN;
         mon_en = RX_DATA_EN;
      end
      mon_rdy_d = mon_full;
      f_ready = !err_q || ERR_READY;
      b = f_data ^ det_q[tpg_pkg::DET_INV_BIT];
      win = {hist_q[22:0], b};
      hist_d = hist_q;
      st_d = st_q;
      didx_d = didx_q;
      mcnt_d = mcnt_q;
      exp_bit = (dsel == tpg_pkg::DSEL_USER) ? usr_q[didx_q] : tpg_pkg::prbs_fb(dsel, hist_q);
      mism = 1'b0;
      err_d = err_q && !ERR_READY;
      if (f_valid && f_ready) begin
         hist_d = win;
         case (st_q)
            tpg_pkg::TPG_HUNT: begin
               if (dsel == tpg_pkg::DSEL_USER) begin
                  if (win == usr_q) begin
                     st_d = tpg_pkg::TPG_LOCK;
                     didx_d = tpg_pkg::USER_MSB;
                  end
               end else if (b == exp_bit) begin
                  mcnt_d = mcnt_q + 5'h01;
                  if (mcnt_q == tpg_pkg::LOCK_MATCHES - 5'h01) begin
                     st_d = tpg_pkg::TPG_LOCK;
                  end
               end else begin
                  mcnt_d = 5'h00;
               end
            end
            tpg_pkg::TPG_LOCK: begin
               mism = (b != exp_bit);
               didx_d = (didx_q == 5'h00) ? tpg_pkg::USER_MSB : didx_q - 5'h01;
            end
            default: st_d = tpg_pkg::TPG_HUNT;
         endcase
      end
      // new mismatch wins over the acknowledge
      if (mism && ERR_CNT_SRC == tpg_pkg::CNT_SRC_PATTERN) begin
         err_d = 1'b1;
      end
      // a detector setting change restarts the hunt
      if (REG_WR && REG_ADDR == tpg_pkg::OFF_DET) begin
         st_d = tpg_pkg::TPG_HUNT;
         mcnt_d = 5'h00;
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (SYS_RST) begin
         gen_q <= tpg_pkg::RST_GEN;
         det_q <= tpg_pkg::RST_DET;
         usr_q <= {3{tpg_pkg::RST_USER}};
         rdata_q <= 8'h00;
         lfsr_q <= 24'h000001;
         hist_q <= 24'h000000;
         uidx_q <= tpg_pkg::USER_MSB;
         didx_q <= tpg_pkg::USER_MSB;
         mcnt_q <= 5'h00;
         ibidx_q <= tpg_pkg::IB_MIN_MSB;
         ins_prev_q <= 1'b0;
         ins_pend_q <= 1'b0;
         done_q <= 1'b0;
         tx_q <= 1'b0;
         rx_q <= 1'b0;
         err_q <= 1'b0;
         mon_rdy_q <= 1'b0;
         st_q <= tpg_pkg::TPG_HUNT;
      end else begin
         gen_q <= gen_d;
         det_q <= det_d;
         usr_q <= usr_d;
         rdata_q <= rdata_d;
         lfsr_q <= lfsr_d;
         hist_q <= hist_d;
         uidx_q <= uidx_d;
         didx_q <= didx_d;
         mcnt_q <= mcnt_d;
         ibidx_q <= ibidx_d;
         ins_prev_q <= ins_prev_d;
         ins_pend_q <= ins_pend_d;
         done_q <= done_d;
         tx_q <= tx_d;
         rx_q <= rx_d;
         err_q <= err_d;
         mon_rdy_q <= mon_rdy_d;
         st_q <= st_d;
      end
   end

   assign REG_RDATA = rdata_q;
   assign TX_DATA_OUT = tx_q;
   assign RX_DATA_OUT = rx_q;
   assign ERROR_INSERT_DONE = done_q;
   assign ERR_EVENT = err_q;
   assign MON_READY = mon_rdy_q;
endmodule
`default_nettype wire

// ### tb/tb.sv
/*
 tb: self-checking bench for tpg_top with a line model.
 assumes: 50 MHz clock, reset held 20 cycles.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic clk = 1'h0, rst = 1'h1, wr = 1'h0, rd = 1'h0, rz = 1'h0, ins = 1'h0;
   logic erdy = 1'h1, run = 1'h0, to_tx = 1'h0, flip = 1'h0, slow = 1'h0, prbs = 1'h0;
   logic [7:0] addr = 8'h00, wd = 8'h00, ibc = 8'h5a, rdata;
   logic [3:0] ck = 4'h0;
   logic [1:0] ibl = 2'h1;
   logic [2:0] src = 3'h7;
   logic [23:0] pat = 24'ha5c30f;
   logic txd, txe, rxd, rxe, txo, rxo, done, ev, mrdy;
   logic got [0:63];
   int err_total = 0, n_compared = 0, n_done = 0, n_ev = 0;
   always #10 clk = ~clk;
   always @(posedge clk) if (done) n_done <= n_done + 1;
   always @(posedge clk) if ($rose(ev)) n_ev <= n_ev + 1;
   tpg_top dut (.REF_CLK(clk), .SYS_RST(rst), .REG_ADDR(addr), .REG_WDATA(wd), .REG_WR(wr),
      .REG_RD(rd), .REG_RDATA(rdata), .REFERENCE_CRYSTAL_CLOCK_EN(ck[0]), .RX_REC_CLK_EN(ck[1]),
      .TX_CLK_EN(ck[2]), .TX_RZ_REC_CLK_EN(ck[3]), .TX_DUAL_RZ(rz), .TX_DATA_IN(txd),
      .TX_DATA_EN(txe), .TX_DATA_OUT(txo), .RX_DATA_IN(rxd), .RX_DATA_EN(rxe),
      .RX_DATA_OUT(rxo), .INBAND_CODE(ibc), .INBAND_LEN(ibl), .ERROR_INSERT(ins),
      .ERROR_INSERT_DONE(done), .ERR_CNT_SRC(src), .ERR_EVENT(ev), .ERR_READY(erdy),
      .MON_READY(mrdy));
   tpg_line_model line (.clk, .rst, .run, .to_tx, .flip, .slow, .prbs, .pat, .tx_d(txd),
      .tx_en(txe), .rx_d(rxd), .rx_en(rxe));
   task automatic check(input logic [23:0] seen, input logic [23:0] exp, input string what);
      n_compared++;
      if (seen !== exp) begin
         err_total++;
         $display("wrong value %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic wreg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
   endtask
   task automatic rreg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      d = rdata;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] v;
      rreg(a, v);
      check(v, e, "register");
   endtask
   // a foreign enable first: it must not advance the generator
   task automatic take(input int n, input int k, input logic dir);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         ck <= 4'h1 << ((k + 1) % 4);
         @(posedge clk);
         ck <= 4'h1 << k;
         @(posedge clk);
         ck <= 4'h0;
         @(negedge clk);
         got[i] = dir ? rxo : txo;
      end
   endtask
   task automatic glitch;
      @(posedge clk);
      flip <= 1'h1;
      @(posedge clk);
      flip <= 1'h0;
      repeat (20) @(posedge clk);
   endtask
   task automatic t_regs;
      rchk(8'h10, 8'h00);
      rchk(8'h11, 8'h03);
      for (int a = 8'h12; a <= 8'h14; a++) begin
         rchk(8'(a), 8'h55);
      end
      wreg(8'h10, 8'hff);
      rchk(8'h10, 8'h7f);
      wreg(8'h11, 8'hff);
      rchk(8'h11, 8'h0f);
      wreg(8'h15, 8'hff);
      rchk(8'h15, 8'h00);
      wreg(8'h11, 8'h03);
      $display("regs test over");
   endtask
   task automatic t_user;
      logic [7:0] g [6] = '{8'h20, 8'h24, 8'h28, 8'h68, 8'h60, 8'h60};
      int k [6] = '{0, 0, 0, 1, 2, 3};
      int nb = 0;
      wreg(8'h12, pat[7:0]);
      wreg(8'h13, pat[15:8]);
      wreg(8'h14, pat[23:16]);
      for (int c = 0; c < 6; c++) begin
         rz <= (c == 5);
         wreg(8'h10, 8'h00);
         wreg(8'h10, g[c]);
         take(30, k[c], g[c][3]);
         for (int i = 0; i < 30; i++) begin
            check(got[i], pat[23 - i % 24] ^ g[c][2], "user bit");
         end
      end
      wreg(8'h10, 8'h00);
      wreg(8'h10, 8'h20);
      take(2, 0, 1'h0);
      @(posedge clk);
      ins <= 1'h1;
      take(20, 0, 1'h0);
      @(posedge clk);
      ins <= 1'h0;
      for (int i = 0; i < 20; i++) begin
         nb += (got[i] !== pat[21 - i]);
      end
      check(nb, 1, "flipped bits");
      check(n_done, 1, "insert done pulses");
      wreg(8'h10, 8'h34);
      take(12, 0, 1'h0);
      for (int i = 0; i < 12; i++) begin
         check(got[i], ibc[5 - i % 6], "inband bit");
      end
      $display("user test over");
   endtask
   task automatic t_prbs;
      int a [4] = '{20, 15, 11, 11};
      int b [4] = '{17, 14, 9, 9};
      int bad, ones;
      for (int s = 0; s < 4; s++) begin
         wreg(8'h10, 8'h00);
         wreg(8'h10, 8'h10 + 8'(s));
         take(60, 0, 1'h0);
         bad = 0;
         ones = 0;
         for (int n = 20; n < 60; n++) begin
            bad += (got[n] !== (got[n - a[s]] ^ got[n - b[s]]));
            ones += got[n];
         end
         check(bad, 0, "prbs taps");
         check(ones > 0, 1, "prbs alive");
      end
      $display("prbs test over");
   endtask
   task automatic t_detect;
      logic [7:0] d [4] = '{8'h03, 8'h07, 8'h0b, 8'h02};
      logic [7:0] s;
      wreg(8'h10, 8'h00);
      for (int c = 0; c < 5; c++) begin
         wreg(8'h11, d[c % 4]);
         to_tx <= d[c % 4][3];
         flip <= d[c % 4][2];
         slow <= (c == 0);
         prbs <= (c == 3);
         run <= 1'h1;
         repeat (130) @(posedge clk);
         rreg(8'h1f, s);
         check(s[0], 1, "lock");
         if (c < 4) run <= 1'h0;
      end
      @(posedge clk);
      src <= 3'h0;
      glitch;
      check(n_ev, 0, "events other source");
      src <= 3'h7;
      glitch;
      check(n_ev, 1, "events");
      erdy <= 1'h0;
      glitch;
      check(mrdy, 0, "fifo full");
      rreg(8'h1f, s);
      check(s[3:2], 2'h3, "status");
      @(posedge clk);
      run <= 1'h0;
      erdy <= 1'h1;
      repeat (40) @(posedge clk);
      check(mrdy, 1, "fifo drained");
      $display("detect test over");
   endtask
   task automatic report_and_stop;
      $display("compared %0d, wrong %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      #1ms;
      err_total++;
      report_and_stop;
   end
   initial begin
      repeat (20) @(posedge clk);
      rst <= 1'h0;
      t_regs;
      t_user;
      t_prbs;
      t_detect;
      report_and_stop;
   end
endmodule
bind tpg_top tpg_checker chk (.REF_CLK, .SYS_RST, .REG_ADDR, .REG_RD, .REG_RDATA, .REFERENCE_CRYSTAL_CLOCK_EN,
   .RX_REC_CLK_EN, .TX_CLK_EN, .TX_RZ_REC_CLK_EN, .TX_DATA_EN, .RX_DATA_EN, .TX_DATA_OUT,
   .RX_DATA_OUT, .ERROR_INSERT_DONE, .ERR_CNT_SRC, .ERR_EVENT, .ERR_READY);
`default_nettype wire

// ### tb/tpg_checker.sv
/*
 tpg_checker: port-level properties of tpg_top.
 assumes: bound to tpg_top, one clock, sync active-high reset.
*/
`timescale 1ns/1ns
`default_nettype none
module tpg_checker (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic SYS_RST,
   // register port
   input wire logic [7:0] REG_ADDR,
   input wire logic REG_RD,
   input wire logic [7:0] REG_RDATA,
   // bit-rate enables and paths
   input wire logic REFERENCE_CRYSTAL_CLOCK_EN,
   input wire logic RX_REC_CLK_EN,
   input wire logic TX_CLK_EN,
   input wire logic TX_RZ_REC_CLK_EN,
   input wire logic TX_DATA_EN,
   input wire logic RX_DATA_EN,
   input wire logic TX_DATA_OUT,
   input wire logic RX_DATA_OUT,
   // error controls
   input wire logic ERROR_INSERT_DONE,
   input wire logic [2:0] ERR_CNT_SRC,
   input wire logic ERR_EVENT,
   input wire logic ERR_READY
);
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (SYS_RST);
   wire logic tick = REFERENCE_CRYSTAL_CLOCK_EN | RX_REC_CLK_EN | TX_CLK_EN | TX_RZ_REC_CLK_EN;
   property p_rd_slot; REG_RDATA != 8'h00 |-> $past(REG_RD); endproperty
   a_rd_slot: assert property (p_rd_slot) else $error("read data outside slot");
   property p_unmapped;
      REG_RD && !(REG_ADDR inside {[8'h10:8'h14], 8'h1f}) |=> REG_RDATA == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_gen_b7; REG_RD && REG_ADDR == 8'h10 |=> !REG_RDATA[7]; endproperty
   a_gen_b7: assert property (p_gen_b7) else $error("gen bit7 reads one");
   property p_det_hi; REG_RD && REG_ADDR == 8'h11 |=> REG_RDATA[7:4] == 4'h0; endproperty
   a_det_hi: assert property (p_det_hi) else $error("det high bits nonzero");
   property p_done_one; ERROR_INSERT_DONE |=> !ERROR_INSERT_DONE; endproperty
   a_done_one: assert property (p_done_one) else $error("insert done too long");
   property p_done_tick; ERROR_INSERT_DONE |-> $past(tick); endproperty
   a_done_tick: assert property (p_done_tick) else $error("insert without tick");
   property p_ev_src; $rose(ERR_EVENT) |-> $past(ERR_CNT_SRC) == 3'h7; endproperty
   a_ev_src: assert property (p_ev_src) else $error("event with other source");
   property p_ev_hold; ERR_EVENT && !ERR_READY |=> ERR_EVENT; endproperty
   a_ev_hold: assert property (p_ev_hold) else $error("event dropped unread");
   property p_tx_stand; !tick && !TX_DATA_EN |=> $stable(TX_DATA_OUT); endproperty
   a_tx_stand: assert property (p_tx_stand) else $error("tx out moved");
   property p_rx_stand; !tick && !RX_DATA_EN |=> $stable(RX_DATA_OUT); endproperty
   a_rx_stand: assert property (p_rx_stand) else $error("rx out moved");
   c_ev: cover property ($rose(ERR_EVENT));
   c_done: cover property (ERROR_INSERT_DONE);
   c_rd: cover property (REG_RD ##1 REG_RDATA == 8'h03);
endmodule
`default_nettype wire

// ### tb/tpg_line_model.sv
/*
 tpg_line_model: bit-serial line feeding the tx or rx input path.
 assumes: bench sets the pattern or picks a 2^11-1 sequence; flip xors the bits sent.
*/
`timescale 1ns/1ns
`default_nettype none
module tpg_line_model (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // bench controls
   input wire logic run,
   input wire logic to_tx,
   input wire logic flip,
   input wire logic slow,
   input wire logic prbs,
   input wire logic [23:0] pat,
   // line side
   output logic tx_d,
   output logic tx_en,
   output logic rx_d,
   output logic rx_en
);
   logic [4:0] idx_q;
   logic [1:0] gap_q;
   logic en_q;
   logic bit_q;
   logic [10:0] lfsr_q;
   always_ff @(posedge clk) begin
      if (rst || !run) begin
         idx_q <= 5'h17;
         gap_q <= 2'h0;
         en_q <= 1'h0;
         bit_q <= rst ? 1'h0 : ~bit_q;
         lfsr_q <= rst ? 11'h001 : lfsr_q;
      end else begin
         gap_q <= gap_q + 2'h1;
         en_q <= !slow || gap_q == 2'h0;
         if (!slow || gap_q == 2'h0) begin
            // newest bit at [0]; feedback from bits 10 and 8
            bit_q <= (prbs ? lfsr_q[10] ^ lfsr_q[8] : pat[idx_q]) ^ flip;
            lfsr_q <= {lfsr_q[9:0], lfsr_q[10] ^ lfsr_q[8]};
            idx_q <= (idx_q == 5'h0) ? 5'h17 : idx_q - 5'h1;
         end else begin
            // unstrobed line toggles, alternating between the last bit and its inverse
            bit_q <= ~bit_q;
         end
      end
   end
   assign tx_d = bit_q;
   assign rx_d = bit_q;
   assign tx_en = en_q & to_tx;
   assign rx_en = en_q & !to_tx;
endmodule
`default_nettype wire
